// file: hw/sfe_erase_seq.sv
// Erase command sequencer behind the two-wire serial link
`timescale 1ns/100ps

// Functional notes
// - A sector erase clears the sector named by address bits 16..10, bits 9..0 ignored.
// - After the sector erase word the sector is erased; the host waits the erase interval.
// - A mass erase ignores every bit of its address field.
// - After the mass erase word the main block is erased; the host waits then sends a stop.
// - Data falling while the clock is high is a start condition.
// - Data rising while the clock is high is a stop condition.
// - One clock pulse per bit; data changes only while the clock is low.
module sfe_erase_seq #(
  parameter int unsigned ERASE_CYC = sfe_pkg::ERASE_INTERVAL_CYC
) (
  // Clock and reset
  input  wire logic                            ref_clk_i,
  input  wire logic                            reset_n_i,
  // Serial link
  input  wire logic                            sck_i,
  input  wire logic                            sda_i,
  output logic                                 sda_o,
  output logic                                 sda_oe_o,
  // Flash array erase control
  output logic                                 sector_erase_o,
  output logic                                 mass_erase_o,
  output logic [sfe_pkg::SECT_BITS-1:0]        sector_o,
  // Status
  output logic                                 busy_o,
  output logic                                 erase_done_o,
  output logic                                 early_stop_o
);

  // ------------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------------
  // Release is synchronous so no flop sees reset end close to a clock edge
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ------------------------------------------------------------------
  // Link sampling
  // ------------------------------------------------------------------
  logic start_ev;
  logic stop_ev;
  logic bit_valid;
  logic bit_val;

  sfe_link_rx u_rx (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n),
    .sck_i       (sck_i),
    .sda_i       (sda_i),
    .start_o     (start_ev),
    .stop_o      (stop_ev),
    .bit_valid_o (bit_valid),
    .bit_o       (bit_val)
  );

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    sfe_pkg::sfe_state_t                 state;
    logic [sfe_pkg::CMD_BITS-1:0]        shreg;
    logic [4:0]                          nbits;
    logic [sfe_pkg::TIMER_W-1:0]         timer;
    logic                                sector_erase;
    logic                                mass_erase;
    logic [sfe_pkg::SECT_BITS-1:0]       sector;
    logic                                done;
    logic                                early;
  } sfe_seq_t;

  sfe_seq_t r;
  sfe_seq_t next_r;

  // ------------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------------
  // Timer counts down to zero, so it loads one less than the length
  function automatic logic [sfe_pkg::TIMER_W-1:0] timer_load(input int unsigned cyc);
    timer_load = sfe_pkg::TIMER_W'(cyc - 1);
  endfunction

  // Word is judged as its last bit arrives, so fields sit one bit lower
  function automatic logic [7:0] opcode_of(input logic [sfe_pkg::CMD_BITS-1:0] sh);
    opcode_of = sh[sfe_pkg::CMD_BITS-2:sfe_pkg::OPC_LO-1];
  endfunction

  function automatic logic [sfe_pkg::SECT_BITS-1:0] sector_of(
    input logic [sfe_pkg::CMD_BITS-1:0] sh
  );
    sector_of = sh[sfe_pkg::SECT_HI-1:sfe_pkg::SECT_LO-1];
  endfunction

  function automatic logic last_bit(input logic [4:0] n);
    last_bit = (n == sfe_pkg::CNT_W_MAX - 5'h01);
  endfunction

  // Both erase kinds start alike; only the flag and the sector differ
  function automatic sfe_seq_t enter_erase(
    input sfe_seq_t                      cur,
    input logic                          mass,
    input logic [sfe_pkg::SECT_BITS-1:0] sect
  );
    enter_erase              = cur;
    enter_erase.state        = sfe_pkg::SFE_ERASE;
    enter_erase.sector_erase = ~mass;
    enter_erase.mass_erase   = mass;
    enter_erase.sector       = sect;
    enter_erase.timer        = timer_load(ERASE_CYC);
  endfunction

  // Both flags drop together so the array never sees a mixed request
  function automatic sfe_seq_t leave_erase(input sfe_seq_t cur);
    leave_erase              = cur;
    leave_erase.state        = sfe_pkg::SFE_DONE;
    leave_erase.sector_erase = 1'b0;
    leave_erase.mass_erase   = 1'b0;
    leave_erase.done         = 1'b1;
  endfunction

  // A new start drops any half-shifted word
  function automatic sfe_seq_t begin_word(input sfe_seq_t cur);
    begin_word       = cur;
    begin_word.state = sfe_pkg::SFE_SHIFT;
    begin_word.nbits = 5'h00;
    begin_word.shreg = '0;
  endfunction

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.done  = 1'b0;
    unique case (r.state)
      sfe_pkg::SFE_IDLE: begin
        next_r.early = 1'b0;
      end
      sfe_pkg::SFE_SHIFT: begin
        if (bit_valid) begin
          // First bit lands in bit 24 after all shifts
          next_r.shreg = {r.shreg[sfe_pkg::CMD_BITS-2:0], bit_val};
          next_r.nbits = r.nbits + 5'h01;
          if (last_bit(r.nbits)) begin
            if (opcode_of(r.shreg) == sfe_pkg::OPC_SECTOR) begin
              // Low ten address bits are dropped
              next_r = enter_erase(next_r, 1'b0, sector_of(r.shreg));
            end else if (opcode_of(r.shreg) == sfe_pkg::OPC_MASS) begin
              // Address field is a don't care; sector reads as zero
              next_r = enter_erase(next_r, 1'b1, '0);
            end else begin
              // Other opcodes belong to read and program; ignored here
              next_r.state = sfe_pkg::SFE_IDLE;
            end
          end
        end
      end
      sfe_pkg::SFE_ERASE: begin
        // Runs to the end even after a stop; a cut erase leaves the array half cleared
        if (r.timer == '0) begin
          next_r = leave_erase(next_r);
        end else begin
          next_r.timer = r.timer - 1'b1;
        end
      end
      sfe_pkg::SFE_DONE: begin
        // Wait for the closing stop
      end
    endcase
    // Framing overrides everything; erase runs to its end regardless
    if (stop_ev) begin
      if (r.state == sfe_pkg::SFE_ERASE && r.timer != '0) begin
        // Stop before the interval: host broke its timing, flag it
        next_r.early = 1'b1;
      end else begin
        // A stop on the last erase cycle is on time and closes the command
        next_r.state = sfe_pkg::SFE_IDLE;
      end
    end else if (start_ev && r.state != sfe_pkg::SFE_ERASE) begin
      next_r = begin_word(next_r);
    end
    if (r.state == sfe_pkg::SFE_ERASE && r.timer == '0 && r.early) begin
      next_r.state = sfe_pkg::SFE_IDLE;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{state: sfe_pkg::SFE_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Erase commands never drive the data line
  assign sda_o          = 1'b0;
  assign sda_oe_o       = 1'b0;
  assign sector_erase_o = r.sector_erase;
  assign mass_erase_o   = r.mass_erase;
  assign sector_o       = r.sector;
  // Busy is a state decode, so it rises with the erase flags
  assign busy_o         = (r.state == sfe_pkg::SFE_ERASE);
  assign erase_done_o   = r.done;
  assign early_stop_o   = r.early;

endmodule // sfe_erase_seq

// file: pkg/sfe_pkg.sv
// Constants and types for the serial flash erase command block
package sfe_pkg;

  // ------------------------------------------------------------------
  // Command word layout
  // ------------------------------------------------------------------
  localparam int unsigned CMD_BITS      = 25;
  localparam int unsigned OPC_HI        = 24;
  localparam int unsigned OPC_LO        = 17;
  localparam int unsigned ADDR_BITS     = 17;
  localparam int unsigned SECT_HI       = 16;
  localparam int unsigned SECT_LO       = 10;
  localparam int unsigned SECT_BITS     = 7;
  localparam logic [7:0]  OPC_SECTOR    = 8'h40;
  localparam logic [7:0]  OPC_MASS      = 8'h60;
  localparam logic [4:0]  CNT_W_MAX     = 5'h19;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam real         CLK_MHZ             = 50.0;
  localparam real         ERASE_INTERVAL_US   = 13500.0;
  localparam int unsigned ERASE_INTERVAL_CYC  = int'(ERASE_INTERVAL_US * CLK_MHZ);
  localparam int unsigned TIMER_W             = 20;

  // ------------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    SFE_IDLE  = 2'b00,
    SFE_SHIFT = 2'b01,
    SFE_ERASE = 2'b10,
    SFE_DONE  = 2'b11
  } sfe_state_t;

endpackage

// file: hw/sfe_link_rx.sv
// Serial link sampler: synchronises clock and data, finds edges and framing
`timescale 1ns/100ps
module sfe_link_rx (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // Link pins
  input  wire logic sck_i,
  input  wire logic sda_i,
  // Decoded events
  output logic      start_o,
  output logic      stop_o,
  output logic      bit_valid_o,
  output logic      bit_o
);

  typedef struct packed {
    logic [1:0] sck_sync;
    logic [1:0] sda_sync;
    logic       sck_d;
    logic       sda_d;
    logic       start;
    logic       stop;
    logic       bit_valid;
    logic       bit_val;
  } sfe_rx_t;

  sfe_rx_t r;
  sfe_rx_t next_r;

  always_comb begin
    next_r          = r;
    next_r.sck_sync = {r.sck_sync[0], sck_i};
    next_r.sda_sync = {r.sda_sync[0], sda_i};
    next_r.sck_d    = r.sck_sync[1];
    next_r.sda_d    = r.sda_sync[1];
    // Clock high both cycles, so a data change here is framing
    next_r.start     = r.sck_d & r.sck_sync[1] & r.sda_d & ~r.sda_sync[1];
    next_r.stop      = r.sck_d & r.sck_sync[1] & ~r.sda_d & r.sda_sync[1];
    // Data is stable while clock is high; take it at the rising edge
    next_r.bit_valid = ~r.sck_d & r.sck_sync[1];
    next_r.bit_val   = r.sda_sync[1];
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '{sck_sync: 2'h3, sda_sync: 2'h3, sck_d: 1'b1, sda_d: 1'b1, default: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign start_o     = r.start;
  assign stop_o      = r.stop;
  assign bit_valid_o = r.bit_valid;
  assign bit_o       = r.bit_val;

endmodule // sfe_link_rx

// file: test/sfe_host_model.sv
// Host side of the two-wire link: frames erase commands
`timescale 1ns/100ps
module sfe_host_model (
  // Clock
  input  wire logic ref_clk_i,
  // Link pins
  output logic      sck_o,
  output logic      sda_o
);
  // --------------------
  // Link driving
  // --------------------
  // Idle with both lines high, as a pulled-up line would rest
  initial begin
    sck_o = 1'h1;
    sda_o = 1'h1;
  end
  task automatic wt(input int c);
    repeat (c) @(posedge ref_clk_i);
  endtask
  // Ends on the rise of the last bit so the bench can time the erase
  task automatic frame(input logic [24:0] w);
    wt(4);
    sda_o <= 1'h0;
    for (int i = 24; i >= 0; i--) begin
      wt(4);
      sck_o <= 1'h0;
      wt(2);
      sda_o <= w[i];
      wt(2);
      sck_o <= 1'h1;
    end
  endtask
  task automatic stop;
    wt(4);
    sck_o <= 1'h0;
    wt(2);
    sda_o <= 1'h0;
    wt(2);
    sck_o <= 1'h1;
    wt(4);
    sda_o <= 1'h1;
  endtask
endmodule // sfe_host_model

// file: test/sfe_erase_seq_checker.sv
// Port assertions for the erase sequencer
`timescale 1ns/100ps
module sfe_erase_seq_checker #(
  parameter int unsigned ERASE_CYC = 200
) (
  // Watched ports
  input wire logic                          ref_clk_i,
  input wire logic                          reset_n_i,
  input wire logic                          sck_i,
  input wire logic                          sda_i,
  input wire logic                          sda_o,
  input wire logic                          sda_oe_o,
  input wire logic                          sector_erase_o,
  input wire logic                          mass_erase_o,
  input wire logic [sfe_pkg::SECT_BITS-1:0] sector_o,
  input wire logic                          busy_o,
  input wire logic                          erase_done_o,
  input wire logic                          early_stop_o
);
  // --------------------
  // Erase length counter
  // --------------------
  logic        er;
  logic [19:0] cnt;
  assign er = sector_erase_o | mass_erase_o;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) cnt <= 20'h0;
    else cnt <= er ? cnt + 20'h1 : 20'h0;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // --------------------
  // Assertions
  // --------------------
  a_no_sda_drive: assert property (!sda_oe_o)
    else $error("sda driven");
  a_one_erase_kind: assert property (!(sector_erase_o && mass_erase_o))
    else $error("two erases at once");
  a_mass_no_sector: assert property (mass_erase_o |-> sector_o == 7'h0)
    else $error("mass erase with sector");
  a_erase_is_busy: assert property (er |-> busy_o)
    else $error("erase while not busy");
  a_sector_held: assert property (sector_erase_o && $past(sector_erase_o) |-> $stable(sector_o))
    else $error("sector moved");
  a_erase_length: assert property ($fell(er) |-> cnt == ERASE_CYC[19:0])
    else $error("erase length wrong");
  a_erase_bounded: assert property (cnt <= ERASE_CYC[19:0])
    else $error("erase too long");
  a_done_follows: assert property ($fell(er) |-> ##[0:1] erase_done_o)
    else $error("no done pulse");
  a_done_pulse: assert property (erase_done_o |=> !erase_done_o)
    else $error("done too long");
  a_busy_erases: assert property ($rose(busy_o) |-> ##[0:1] er)
    else $error("busy without erase");
  a_early_in_erase: assert property ($rose(early_stop_o) |-> busy_o)
    else $error("early stop while idle");
  c_sector: cover property ($rose(sector_erase_o));
  c_mass: cover property ($rose(mass_erase_o));
  c_early: cover property ($rose(early_stop_o));
endmodule // sfe_erase_seq_checker
bind sfe_erase_seq sfe_erase_seq_checker #(.ERASE_CYC(ERASE_CYC)) chk_i (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .sck_i(sck_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .sector_erase_o(sector_erase_o),
  .mass_erase_o(mass_erase_o), .sector_o(sector_o), .busy_o(busy_o),
  .erase_done_o(erase_done_o), .early_stop_o(early_stop_o));

// file: test/tb_top.sv
// Self-checking bench for the erase sequencer
`timescale 1ns/100ps
module tb_top;
  // --------------------
  // Signals and instances
  // --------------------
  localparam int unsigned ER = 200;
  logic       ref_clk_i = 1'h0;
  logic       reset_n_i = 1'h0;
  logic       sck_i, sda_i, sda_o, sda_oe_o, sector_erase_o, mass_erase_o;
  logic       busy_o, erase_done_o, early_stop_o;
  logic [6:0] sector_o;
  int         n_mismatch = 0;
  int         checked = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  sfe_host_model sfe_host_model_i (.ref_clk_i(ref_clk_i), .sck_o(sck_i), .sda_o(sda_i));
  sfe_erase_seq #(.ERASE_CYC(ER)) sfe_erase_seq_i (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .sck_i(sck_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .sector_erase_o(sector_erase_o),
    .mass_erase_o(mass_erase_o), .sector_o(sector_o), .busy_o(busy_o),
    .erase_done_o(erase_done_o), .early_stop_o(early_stop_o));
  // --------------------
  // Tasks
  // --------------------
  task automatic end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // Early stop is sent in parallel so the erase timing is still measured
  task automatic erase(input logic [7:0] op, input logic [16:0] ad, input logic ms,
                       input logic early);
    int   n;
    logic dn, es;
    sfe_host_model_i.frame({op, ad});
    n = 0;
    while ((sector_erase_o | mass_erase_o) !== 1'h1) begin
      @(posedge ref_clk_i);
      #1;
      n++;
      if (n > 40) begin
        n_mismatch++;
        end_sim;
      end
    end
    chk("sector", {1'h0, ms ? 7'h0 : ad[16:10]}, {1'h0, sector_o});
    chk("mass", {7'h0, ms}, {7'h0, mass_erase_o});
    chk("busy", 8'h1, {7'h0, busy_o});
    chk("sda_drive", 8'h0, {6'h0, sda_oe_o, sda_o});
    if (early) begin
      fork
        sfe_host_model_i.stop;
      join_none
    end
    n = 0;
    es = 1'h0;
    while ((sector_erase_o | mass_erase_o) === 1'h1 && n < ER + 9) begin
      es |= early_stop_o;
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    if (n >= ER + 9) begin
      n_mismatch++;
      end_sim;
    end
    dn = erase_done_o;
    @(posedge ref_clk_i);
    #1;
    dn |= erase_done_o;
    chk("erase_len", 8'(ER), 8'(n));
    chk("done", 8'h1, {7'h0, dn});
    chk("early", {7'h0, early}, {7'h0, es});
    if (!early) sfe_host_model_i.stop;
    repeat (8) @(posedge ref_clk_i);
    #1;
    chk("idle", 8'h0, {6'h0, busy_o, early_stop_o});
  endtask
  // Sector numbers asymmetric so a reversed shift shows up
  task automatic t_sector;
    erase(8'h40, {7'h01, 10'h3FF}, 1'h0, 1'h0);
    erase(8'h40, {7'h7E, 10'h000}, 1'h0, 1'h0);
  endtask
  task automatic t_mass;
    erase(8'h60, 17'h1FFFF, 1'h1, 1'h0);
  endtask
  task automatic t_early;
    erase(8'h40, 17'h0AC00, 1'h0, 1'h1);
  endtask
  task automatic t_refuse;
    sfe_host_model_i.frame(25'h0400000);
    repeat (30) begin
      @(posedge ref_clk_i);
      #1;
      chk("refused", 8'h0, {7'h0, busy_o});
    end
    sfe_host_model_i.stop;
  endtask
  initial begin
    repeat (6) @(posedge ref_clk_i);
    reset_n_i <= 1'h1;
    repeat (4) @(posedge ref_clk_i);
    t_sector;
    t_mass;
    t_early;
    t_refuse;
    end_sim;
  end
endmodule // tb_top
